// ---- rtl/timer16.sv ----
`timescale 1ns/1ps
module timer16 (
    input wire logic ref_clk,
    input wire logic rst,
    input wire timer16_pkg::loc_t io_addr,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire timer16_pkg::byte_t io_wdata,
    output timer16_pkg::byte_t io_rdata,
    input wire logic [2:0] clock_select_field,
    input wire logic timer_clock,
    input wire logic [3:0] wave_mode_field,
    input wire timer16_pkg::count_t ocr_top,
    input wire logic noise_filter_enable,
    input wire logic edge_select,
    input wire logic comparator_capture_select,
    input wire logic capture_pin,
    input wire logic comparator_output,
    input wire logic capture_irq_enable,
    input wire logic overflow_irq_enable,
    input wire logic flag_wr,
    input wire timer16_pkg::byte_t flag_wdata,
    input wire logic capture_irq_ack,
    input wire logic overflow_irq_ack,
    output logic capture_flag,
    output logic overflow_flag,
    output logic capture_irq,
    output logic overflow_irq
);
    import timer16_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Mode decoding.
    function automatic logic icr_is_top(input logic [3:0] m);
        return (m == 4'h8) || (m == 4'hA) || (m == 4'hC) || (m == 4'hE);
    endfunction

    function automatic logic dual_slope(input logic [3:0] m);
        return (m >= 4'h1 && m <= 4'h3) || (m >= 4'h8 && m <= 4'hB);
    endfunction

    function automatic ovf_at_t ovf_point(input logic [3:0] m);
        if (dual_slope(m)) return OVF_AT_BOTTOM;
        if ((m >= 4'h5 && m <= 4'h7) || m == 4'hE || m == 4'hF) return OVF_AT_TOP;
        return OVF_AT_MAX;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    count_t cnt_q;
    count_t cnt_d;
    count_t icr_q;
    byte_t temp_q;
    byte_t rdata_q;
    logic down_q;
    logic down_d;
    logic cap_flag_q;
    logic ovf_flag_q;
    logic tick;
    logic ovf_evt;
    logic cnt_wr;
    logic icr_wr;
    logic icr_top;
    count_t top;
    ovf_at_t ovf_at;
    capture_if cap ();

    assign icr_top = icr_is_top(wave_mode_field);
    assign ovf_at = ovf_point(wave_mode_field);
    assign tick = timer_clock && (clock_select_field != CS_STOP);
    assign cnt_wr = io_wr && (io_addr == LOC_CNT_LO);
    assign icr_wr = io_wr && (io_addr == LOC_CAP_LO) && icr_top;

    // Top of the count sequence for the selected mode.
    always_comb begin
        unique case (wave_mode_field)
            4'h1, 4'h5: top = TOP_8BIT;
            4'h2, 4'h6: top = TOP_9BIT;
            4'h3, 4'h7: top = TOP_10BIT;
            4'h4, 4'h9, 4'hB, 4'hF: top = ocr_top;
            4'h8, 4'hA, 4'hC, 4'hE: top = icr_q;
            default: top = COUNT_MAX;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Counter next state.
    always_comb begin
        cnt_d = cnt_q;
        down_d = down_q;
        ovf_evt = 1'b0;
        if (cnt_wr) begin
            cnt_d = {temp_q, io_wdata};
        end else if (tick) begin
            if (dual_slope(wave_mode_field)) begin
                if (!down_q) begin
                    if (cnt_q >= top) begin
                        down_d = 1'b1;
                        cnt_d = cnt_q - COUNT_ONE;
                    end else begin
                        cnt_d = cnt_q + COUNT_ONE;
                    end
                end else if (cnt_q == COUNT_BOTTOM) begin
                    down_d = 1'b0;
                    cnt_d = cnt_q + COUNT_ONE;
                end else begin
                    cnt_d = cnt_q - COUNT_ONE;
                end
            end else if (cnt_q == top) begin
                cnt_d = COUNT_BOTTOM;
            end else begin
                cnt_d = cnt_q + COUNT_ONE;
            end
            unique case (ovf_at)
                OVF_AT_MAX: ovf_evt = (cnt_q == COUNT_MAX);
                OVF_AT_TOP: ovf_evt = (cnt_q == top);
                OVF_AT_BOTTOM: ovf_evt = down_q && (cnt_q == COUNT_BOTTOM);
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cnt_q <= COUNT_BOTTOM;
            down_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            down_q <= down_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Shared high-byte latch.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            temp_q <= 8'h00;
        end else if (io_wr && (io_addr == LOC_CNT_HI || io_addr == LOC_CAP_HI)) begin
            temp_q <= io_wdata;
        end else if (io_rd && io_addr == LOC_CNT_LO) begin
            temp_q <= cnt_q[15:8];
        end else if (io_rd && io_addr == LOC_CAP_LO) begin
            temp_q <= icr_q[15:8];
        end
    end

    // Read data; high-byte locations return the latch.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rdata_q <= 8'h00;
        end else if (io_rd) begin
            unique case (io_addr)
                LOC_CNT_LO: rdata_q <= cnt_q[7:0];
                LOC_CNT_HI: rdata_q <= temp_q;
                LOC_CAP_LO: rdata_q <= icr_q[7:0];
                LOC_CAP_HI: rdata_q <= temp_q;
            endcase
        end
    end

    assign io_rdata = rdata_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Input capture unit.
    assign cap.cmp_select = comparator_capture_select;
    assign cap.filter_en = noise_filter_enable;
    assign cap.rising = edge_select;
    assign cap.enable = !icr_top;

    capture_conditioner #(
        .SAMPLES(FILTER_SAMPLES)
    ) u_cond (
        .ref_clk(ref_clk),
        .rst(rst),
        .capture_pin(capture_pin),
        .comparator_output(comparator_output),
        .cap(cap)
    );

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            icr_q <= COUNT_BOTTOM;
        end else if (icr_wr) begin
            icr_q <= {temp_q, io_wdata};
        end else if (cap.event_p) begin
            icr_q <= cnt_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Flags: a setting event in the clearing cycle wins.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cap_flag_q <= 1'b0;
        end else if (cap.event_p) begin
            cap_flag_q <= 1'b1;
        end else if ((flag_wr && flag_wdata[CAP_FLAG_BIT]) || capture_irq_ack) begin
            cap_flag_q <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ovf_flag_q <= 1'b0;
        end else if (ovf_evt) begin
            ovf_flag_q <= 1'b1;
        end else if ((flag_wr && flag_wdata[OVF_FLAG_BIT]) || overflow_irq_ack) begin
            ovf_flag_q <= 1'b0;
        end
    end

    assign capture_flag = cap_flag_q;
    assign overflow_flag = ovf_flag_q;
    assign capture_irq = cap_flag_q && capture_irq_enable;
    assign overflow_irq = ovf_flag_q && overflow_irq_enable;

    ////////////////////////////////////////////////////////////////////////////////
    sequence hi_then_lo_s;
        io_wr && io_addr == LOC_CNT_HI ##1 io_wr && io_addr == LOC_CNT_LO;
    endsequence

    sequence lo_read_s;
        io_rd && io_addr == LOC_CNT_LO;
    endsequence

    sequence hi_read_s;
        io_rd && io_addr == LOC_CNT_HI;
    endsequence

    word_write_a: assert property (@(posedge ref_clk) disable iff (rst)
        hi_then_lo_s |=> cnt_q == {$past(io_wdata, 2), $past(io_wdata)})
        else $error("Counter word write did not load both bytes.");

    cpu_wins_a: assert property (@(posedge ref_clk) disable iff (rst)
        cnt_wr && tick |=> cnt_q == $past({temp_q, io_wdata}))
        else $error("Counting overrode a CPU counter write.");

    word_read_a: assert property (@(posedge ref_clk) disable iff (rst)
        lo_read_s ##1 (hi_read_s and !io_wr) |=> io_rdata == $past(cnt_q[15:8], 2))
        else $error("High byte read did not return latched counter byte.");

    cap_read_a: assert property (@(posedge ref_clk) disable iff (rst)
        io_rd && io_addr == LOC_CAP_LO |=> temp_q == $past(icr_q[15:8]))
        else $error("Capture low read did not latch the high byte.");

    stopped_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
        clock_select_field == CS_STOP && !cnt_wr |=> cnt_q == $past(cnt_q))
        else $error("Counter moved while stopped.");

    up_step_a: assert property (@(posedge ref_clk) disable iff (rst)
        tick && !cnt_wr && wave_mode_field == 4'h0 |=> cnt_q == $past(cnt_q) + COUNT_ONE)
        else $error("Normal mode did not increment by one.");

    capture_copy_a: assert property (@(posedge ref_clk) disable iff (rst)
        cap.event_p && !icr_wr |=> icr_q == $past(cnt_q) && cap_flag_q)
        else $error("Capture did not copy counter and set flag together.");

    flag_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
        flag_wr && !flag_wdata[CAP_FLAG_BIT] && !capture_irq_ack && cap_flag_q
        |=> cap_flag_q)
        else $error("Writing zero cleared the capture flag.");

    ack_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
        capture_irq_ack && !cap.event_p |=> !cap_flag_q)
        else $error("Serviced capture interrupt did not clear flag.");

    icr_guard_a: assert property (@(posedge ref_clk) disable iff (rst)
        !icr_top && !cap.event_p |=> icr_q == $past(icr_q))
        else $error("Capture register changed without capture or top mode.");

    ovf_max_a: assert property (@(posedge ref_clk) disable iff (rst)
        tick && !cnt_wr && wave_mode_field == 4'h0 && cnt_q == COUNT_MAX
        |=> ovf_flag_q && cnt_q == COUNT_BOTTOM)
        else $error("Overflow at maximum not flagged.");

    ////////////////////////////////////////////////////////////////////////////////
    // Latch, read-back, counter, capture register and flag checks.
    sequence hi_write_s;
        io_wr && (io_addr == LOC_CNT_HI || io_addr == LOC_CAP_HI);
    endsequence

    latch_load_a: assert property (@(posedge ref_clk) disable iff (rst)
        hi_write_s |=> temp_q == $past(io_wdata))
        else $error("High byte write did not load the latch.");

    hi_write_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
        io_wr && io_addr == LOC_CNT_HI && !tick |=> cnt_q == $past(cnt_q))
        else $error("High byte write reached the counter.");

    cnt_hi_read_a: assert property (@(posedge ref_clk) disable iff (rst)
        hi_read_s |=> io_rdata == $past(temp_q))
        else $error("Counter high read did not return the latch.");

    lo_read_a: assert property (@(posedge ref_clk) disable iff (rst)
        lo_read_s |=> io_rdata == $past(cnt_q[7:0]) && temp_q == $past(cnt_q[15:8]))
        else $error("Counter low read returned or latched wrong bytes.");

    lo_write_a: assert property (@(posedge ref_clk) disable iff (rst)
        cnt_wr |=> cnt_q == $past({temp_q, io_wdata}))
        else $error("Counter low write did not load the whole word.");

    no_tick_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
        !tick && !cnt_wr |=> cnt_q == $past(cnt_q))
        else $error("Counter moved without a timer clock.");

    wrap_top_a: assert property (@(posedge ref_clk) disable iff (rst)
        tick && !cnt_wr && !dual_slope(wave_mode_field) && cnt_q == top
        |=> cnt_q == COUNT_BOTTOM)
        else $error("Single slope count did not restart at top.");

    rdata_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
        !io_rd |=> io_rdata == $past(io_rdata))
        else $error("Read data changed without a read.");

    cap_lo_read_a: assert property (@(posedge ref_clk) disable iff (rst)
        io_rd && io_addr == LOC_CAP_LO |=> io_rdata == $past(icr_q[7:0]))
        else $error("Capture low read returned the wrong byte.");

    cap_hi_read_a: assert property (@(posedge ref_clk) disable iff (rst)
        io_rd && io_addr == LOC_CAP_HI |=> io_rdata == $past(temp_q))
        else $error("Capture high read did not return the latch.");

    icr_load_a: assert property (@(posedge ref_clk) disable iff (rst)
        icr_wr |=> icr_q == $past({temp_q, io_wdata}))
        else $error("Capture register write did not load the whole word.");

    icr_gate_a: assert property (@(posedge ref_clk) disable iff (rst)
        icr_top |=> !cap.event_p)
        else $error("Capture event while capture register is top.");

    cap_set_a: assert property (@(posedge ref_clk) disable iff (rst)
        cap.event_p |=> cap_flag_q)
        else $error("Capture event did not set the flag.");

    cap_one_clr_a: assert property (@(posedge ref_clk) disable iff (rst)
        flag_wr && flag_wdata[CAP_FLAG_BIT] && !cap.event_p |=> !cap_flag_q)
        else $error("Writing one did not clear the capture flag.");

    ovf_set_a: assert property (@(posedge ref_clk) disable iff (rst)
        ovf_evt |=> ovf_flag_q)
        else $error("Overflow event did not set the flag.");

    ovf_ack_a: assert property (@(posedge ref_clk) disable iff (rst)
        overflow_irq_ack && !ovf_evt |=> !ovf_flag_q)
        else $error("Serviced overflow interrupt did not clear flag.");

    ovf_one_clr_a: assert property (@(posedge ref_clk) disable iff (rst)
        flag_wr && flag_wdata[OVF_FLAG_BIT] && !ovf_evt |=> !ovf_flag_q)
        else $error("Writing one did not clear the overflow flag.");

    ovf_zero_wr_a: assert property (@(posedge ref_clk) disable iff (rst)
        flag_wr && !flag_wdata[OVF_FLAG_BIT] && !overflow_irq_ack && ovf_flag_q
        |=> ovf_flag_q)
        else $error("Writing zero cleared the overflow flag.");
endmodule

// ---- rtl/timer16_pkg.sv ----
// Behaviour
// - Counter seen as two byte locations.
// - High-byte location accesses the shared latch.
// - Low read fills latch; low write loads.
// - Clock select zero stops the counter.
// - Counter readable and writable while stopped.
// - CPU counter write beats count or clear.
// - Each tick clears, increments or decrements.
// - Wave mode sets sequence and overflow point.
// - Chosen edge copies counter into capture register.
// - Capture flag set with the copy.
// - Enabled flag interrupts; serviced interrupt clears it.
// - Writing one clears flag; zero ignored.
// - Capture low read latches high byte.
// - Capture register writable only as top.
// - Comparator select swaps trigger source.
// - Source switch may capture; software clears flag.
// - Filter changes after four equal samples.
// - Filter adds four system clock delay.
// - Capture input off when capture is top.
// - Software driving pin port triggers capture.
// - New capture overwrites unread value.
// - Low write moves both bytes together.
// - All ones is maximum, apart from top.
package timer16_pkg;
    typedef logic [1:0] loc_t;
    typedef logic [15:0] count_t;
    typedef logic [7:0] byte_t;
    typedef enum logic [1:0] {OVF_AT_MAX, OVF_AT_TOP, OVF_AT_BOTTOM} ovf_at_t;
    localparam loc_t LOC_CNT_LO = 2'h0;
    localparam loc_t LOC_CNT_HI = 2'h1;
    localparam loc_t LOC_CAP_LO = 2'h2;
    localparam loc_t LOC_CAP_HI = 2'h3;
    localparam logic [2:0] CS_STOP = 3'h0;
    localparam count_t COUNT_MAX = 16'hFFFF;
    localparam count_t COUNT_BOTTOM = 16'h0000;
    localparam count_t COUNT_ONE = 16'h0001;
    localparam count_t TOP_8BIT = 16'h00FF;
    localparam count_t TOP_9BIT = 16'h01FF;
    localparam count_t TOP_10BIT = 16'h03FF;
    localparam int OVF_FLAG_BIT = 0;
    localparam int CAP_FLAG_BIT = 5;
    localparam int FILTER_SAMPLES = 4;
    localparam int SYNC_STAGES = 3;
endpackage

// ---- rtl/capture_if.sv ----
`timescale 1ns/1ps
interface capture_if;
    logic cmp_select;
    logic filter_en;
    logic rising;
    logic enable;
    logic event_p;
    modport ctrl (output cmp_select, output filter_en, output rising, output enable,
        input event_p);
    modport cond (input cmp_select, input filter_en, input rising, input enable,
        output event_p);
endinterface

// ---- rtl/capture_conditioner.sv ----
`timescale 1ns/1ps
module capture_conditioner #(
    parameter int SAMPLES = timer16_pkg::FILTER_SAMPLES
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic capture_pin,
    input wire logic comparator_output,
    capture_if.cond cap
);
    import timer16_pkg::*;

    if (SAMPLES < 2) begin : g_bad_samples
        $error("Filter needs at least two samples.");
    end

    ////////////////////////////////////////////////////////////////////////////////
    logic [SYNC_STAGES-1:0] pin_sync_q;
    logic [SYNC_STAGES-1:0] cmp_sync_q;
    logic pin_clean_q;
    logic cmp_clean_q;
    logic [SAMPLES-1:0] samp_q;
    logic filt_q;
    logic prev_q;
    logic level;
    logic event_q;

    // Three-stage synchronisers; a change counts once stages two and three agree.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pin_sync_q <= '0;
            cmp_sync_q <= '0;
        end else begin
            pin_sync_q <= {pin_sync_q[SYNC_STAGES-2:0], capture_pin};
            cmp_sync_q <= {cmp_sync_q[SYNC_STAGES-2:0], comparator_output};
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pin_clean_q <= 1'b0;
            cmp_clean_q <= 1'b0;
        end else begin
            if (pin_sync_q[1] == pin_sync_q[2]) pin_clean_q <= pin_sync_q[2];
            if (cmp_sync_q[1] == cmp_sync_q[2]) cmp_clean_q <= cmp_sync_q[2];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Noise filter: output follows only when every sample in the window agrees.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            samp_q <= '0;
            filt_q <= 1'b0;
        end else begin
            samp_q <= {samp_q[SAMPLES-2:0], cap.cmp_select ? cmp_clean_q : pin_clean_q};
            if (&samp_q) filt_q <= 1'b1;
            else if (~|samp_q) filt_q <= 1'b0;
        end
    end

    assign level = cap.filter_en ? filt_q : samp_q[0];

    // Edge detector picks the direction chosen by the edge select bit.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            prev_q <= 1'b0;
            event_q <= 1'b0;
        end else begin
            prev_q <= level;
            event_q <= cap.enable && (level != prev_q) && (level == cap.rising);
        end
    end

    assign cap.event_p = event_q;

    ////////////////////////////////////////////////////////////////////////////////
    filter_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
        $changed(filt_q) |-> $past(&samp_q) || $past(~|samp_q))
        else $error("Filter output changed without agreeing samples.");

    edge_dir_a: assert property (@(posedge ref_clk) disable iff (rst)
        event_q |-> $past(level) == $past(cap.rising) && $past(level) != $past(prev_q))
        else $error("Capture event on the wrong edge.");

    gate_off_a: assert property (@(posedge ref_clk) disable iff (rst)
        !$past(cap.enable) |-> !event_q)
        else $error("Capture event while capture input is disabled.");
endmodule

// ---- test/capture_source.sv ----
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Drives the capture pin and comparator output out of phase with the clock.
module capture_source (
    input wire logic ref_clk,
    input wire logic pin_req,
    input wire logic cmp_req,
    output logic capture_pin,
    output logic comparator_output
);
    initial begin
        capture_pin = 1'b0;
        comparator_output = 1'b0;
    end
    always @(posedge ref_clk) begin
        #3;
        capture_pin = pin_req;
        comparator_output = cmp_req;
    end
endmodule

// ---- test/testbench.sv ----
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module testbench;
    import timer16_pkg::*;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    loc_t io_addr = LOC_CNT_LO;
    logic io_wr = 1'b0;
    logic io_rd = 1'b0;
    byte_t io_wdata = 8'h00;
    byte_t io_rdata;
    logic [2:0] cs = 3'h0;
    logic tick = 1'b0;
    logic [3:0] wave = 4'h0;
    count_t ocr_top = 16'h0000;
    logic filt = 1'b0;
    logic edge_sel = 1'b1;
    logic cmp_sel = 1'b0;
    logic pin_req = 1'b0;
    logic cmp_req = 1'b0;
    logic capture_pin, comparator_output;
    logic cap_en = 1'b0;
    logic ovf_en = 1'b0;
    logic flag_wr = 1'b0;
    byte_t flag_wdata = 8'h00;
    logic cap_ack = 1'b0;
    logic ovf_ack = 1'b0;
    logic capture_flag, overflow_flag, capture_irq, overflow_irq;
    int n_fail = 0;
    int n_compared = 0;
    int seed = 7;
    int lat0, lat1;
    logic [15:0] v;
    logic [31:0] r;
    logic rd_pend = 1'b0;
    byte_t exp_q[$];
    int m;
    logic [3:0] modes[4] = '{4'h8, 4'hA, 4'hC, 4'hE};

    always #5 ref_clk = ~ref_clk;

    capture_source i_src (.ref_clk(ref_clk), .pin_req(pin_req), .cmp_req(cmp_req),
        .capture_pin(capture_pin), .comparator_output(comparator_output));

    timer16 i_timer16 (.ref_clk(ref_clk), .rst(rst), .io_addr(io_addr), .io_wr(io_wr),
        .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata), .clock_select_field(cs),
        .timer_clock(tick), .wave_mode_field(wave), .ocr_top(ocr_top),
        .noise_filter_enable(filt), .edge_select(edge_sel),
        .comparator_capture_select(cmp_sel), .capture_pin(capture_pin),
        .comparator_output(comparator_output), .capture_irq_enable(cap_en),
        .overflow_irq_enable(ovf_en), .flag_wr(flag_wr), .flag_wdata(flag_wdata),
        .capture_irq_ack(cap_ack), .overflow_irq_ack(ovf_ack), .capture_flag(capture_flag),
        .overflow_flag(overflow_flag), .capture_irq(capture_irq), .overflow_irq(overflow_irq));

    ////////////////////////////////////////////////////////////////////////////////
    task results;
        if (n_fail == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task cmp8(input byte_t got, input byte_t exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task cmp1(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One bus cycle: every strobe is assigned once per edge, so cycles can run back to back.
    task bus(input logic w, input logic rd, input loc_t a, input byte_t d, input logic t);
        io_wr <= w;
        io_rd <= rd;
        io_addr <= a;
        io_wdata <= d;
        tick <= t;
        @(posedge ref_clk);
    endtask
    task idle(input int n);
        repeat (n) bus(1'b0, 1'b0, LOC_CNT_LO, 8'h00, 1'b0);
    endtask
    task wr16(input loc_t lo, input logic [15:0] d);
        bus(1'b1, 1'b0, loc_t'(lo + 2'h1), d[15:8], 1'b0);
        bus(1'b1, 1'b0, lo, d[7:0], 1'b0);
        idle(1);
    endtask
    task rd16(input loc_t lo, input logic [15:0] e);
        exp_q.push_back(e[7:0]);
        bus(1'b0, 1'b1, lo, 8'h00, 1'b0);
        exp_q.push_back(e[15:8]);
        bus(1'b0, 1'b1, loc_t'(lo + 2'h1), 8'h00, 1'b0);
        idle(1);
    endtask
    task flagw(input byte_t d, input logic ca, input logic oa);
        flag_wr <= (ca | oa) ? 1'b0 : 1'b1;
        flag_wdata <= d;
        cap_ack <= ca;
        ovf_ack <= oa;
        @(posedge ref_clk);
        flag_wr <= 1'b0;
        cap_ack <= 1'b0;
        ovf_ack <= 1'b0;
        @(posedge ref_clk);
    endtask
    task wait_cap(output int lat);
        lat = 0;
        while (capture_flag !== 1'b1 && lat < 40) begin
            @(negedge ref_clk);
            lat++;
        end
        @(posedge ref_clk);
        if (lat >= 40) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, capture_flag, 1'b1);
            results();
        end
    endtask
    task no_cap;
        idle(20);
        cmp1(capture_flag, 1'b0);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Read data is valid the cycle after the read strobe is taken.
    always @(posedge ref_clk) rd_pend <= io_rd & ~rst;
    always @(negedge ref_clk) begin
        if (rd_pend) begin
            if (exp_q.size() == 0) begin
                n_fail++;
                $display("MISMATCH t=%0t got=%h exp=%h", $time, io_rdata, 8'h00);
            end else begin
                cmp8(io_rdata, exp_q.pop_front());
            end
        end
    end

    initial begin
        repeat (16) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        cmp1(capture_flag, 1'b0);
        cmp1(overflow_flag, 1'b0);
        rd16(LOC_CNT_LO, 16'h0000);
        wr16(LOC_CNT_LO, 16'h01FF);
        bus(1'b1, 1'b0, LOC_CNT_HI, 8'hAB, 1'b0);
        rd16(LOC_CNT_LO, 16'h01FF);
        repeat (5) bus(1'b0, 1'b0, LOC_CNT_LO, 8'h00, 1'b1);
        rd16(LOC_CNT_LO, 16'h01FF);
        r = $random(seed);
        cs <= (r[2:0] == 3'h0) ? 3'h1 : r[2:0];
        repeat (5) bus(1'b0, 1'b0, LOC_CNT_LO, 8'h00, 1'b1);
        rd16(LOC_CNT_LO, 16'h0204);
        bus(1'b1, 1'b0, LOC_CNT_HI, 8'h12, 1'b1);
        bus(1'b1, 1'b0, LOC_CNT_LO, 8'h34, 1'b1);
        idle(1);
        rd16(LOC_CNT_LO, 16'h1234);
        wr16(LOC_CNT_LO, 16'hFFFE);
        bus(1'b0, 1'b0, LOC_CNT_LO, 8'h00, 1'b1);
        idle(1);
        cmp1(overflow_flag, 1'b0);
        bus(1'b0, 1'b0, LOC_CNT_LO, 8'h00, 1'b1);
        ovf_en <= 1'b1;
        idle(1);
        cmp1(overflow_flag, 1'b1);
        cmp1(overflow_irq, 1'b1);
        rd16(LOC_CNT_LO, 16'h0000);
        flagw(8'hFE, 1'b0, 1'b0);
        cmp1(overflow_flag, 1'b1);
        flagw(8'h00, 1'b0, 1'b1);
        cmp1(overflow_flag, 1'b0);
        wave <= 4'h4;
        ocr_top <= 16'h0010;
        wr16(LOC_CNT_LO, 16'h0010);
        bus(1'b0, 1'b0, LOC_CNT_LO, 8'h00, 1'b1);
        idle(1);
        rd16(LOC_CNT_LO, 16'h0000);
        cmp1(overflow_flag, 1'b0);
        wave <= 4'h0;
        cs <= CS_STOP;
        v = 16'($random(seed));
        wr16(LOC_CNT_LO, v);
        pin_req <= 1'b1;
        wait_cap(lat0);
        rd16(LOC_CAP_LO, v);
        cmp1(capture_irq, 1'b0);
        cap_en <= 1'b1;
        idle(1);
        cmp1(capture_irq, 1'b1);
        flagw(8'h00, 1'b1, 1'b0);
        cmp1(capture_flag, 1'b0);
        pin_req <= 1'b0;
        no_cap();
        edge_sel <= 1'b0;
        flagw(8'h21, 1'b0, 1'b0);
        pin_req <= 1'b1;
        no_cap();
        v = 16'($random(seed));
        wr16(LOC_CNT_LO, v);
        pin_req <= 1'b0;
        wait_cap(lat1);
        v = 16'($random(seed));
        wr16(LOC_CNT_LO, v);
        edge_sel <= 1'b1;
        pin_req <= 1'b1;
        idle(20);
        rd16(LOC_CAP_LO, v);
        flagw(8'hDF, 1'b0, 1'b0);
        cmp1(capture_flag, 1'b1);
        flagw(8'h20, 1'b0, 1'b0);
        cmp1(capture_flag, 1'b0);
        pin_req <= 1'b0;
        filt <= 1'b1;
        idle(20);
        pin_req <= 1'b1;
        wait_cap(lat1);
        cmp8(8'(lat1 - lat0), 8'h04);
        flagw(8'h20, 1'b0, 1'b0);
        pin_req <= 1'b0;
        idle(10);
        pin_req <= 1'b1;
        idle(3);
        pin_req <= 1'b0;
        no_cap();
        filt <= 1'b0;
        pin_req <= 1'b1;
        idle(3);
        pin_req <= 1'b0;
        wait_cap(lat1);
        cmp_sel <= 1'b1;
        idle(20);
        flagw(8'h20, 1'b0, 1'b0);
        pin_req <= 1'b1;
        no_cap();
        cmp_req <= 1'b1;
        wait_cap(lat1);
        cmp_sel <= 1'b0;
        idle(20);
        flagw(8'h20, 1'b0, 1'b0);
        for (m = 0; m < 4; m++) begin
            wave <= modes[m];
            v = 16'($random(seed));
            wr16(LOC_CAP_LO, v);
            rd16(LOC_CAP_LO, v);
            pin_req <= 1'b0;
            idle(10);
            pin_req <= 1'b1;
            no_cap();
        end
        bus(1'b1, 1'b0, LOC_CNT_HI, 8'h5A, 1'b0);
        bus(1'b1, 1'b0, LOC_CNT_LO, 8'h01, 1'b0);
        bus(1'b1, 1'b0, LOC_CAP_LO, 8'h02, 1'b0);
        idle(1);
        rd16(LOC_CNT_LO, 16'h5A01);
        rd16(LOC_CAP_LO, 16'h5A02);
        wave <= 4'h0;
        wr16(LOC_CAP_LO, 16'h1111);
        rd16(LOC_CAP_LO, 16'h5A02);
        idle(4);
        results();
    end
endmodule
